// ### rtl/eeprom_pgm_pkg.sv
// Purpose: Shared constants and carrier types for the EEPROM program/erase control block.
// Assumes: 8-bit register port, 128-byte array in four 32-byte blocks.
// Notes:   Array addresses are 7-bit offsets within the EEPROM window.
package eeprom_pgm_pkg;

    localparam int          ADDR_W        = 7;
    localparam int          DATA_W        = 8;
    localparam logic [1:0]  REG_CTRL      = 2'h0;
    localparam logic [1:0]  REG_LATCHED   = 2'h1;
    localparam logic [1:0]  REG_LDATA     = 2'h2;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [7:0]  RD_ZERO       = 8'h00;
    localparam int          BIT_PGM       = 0;
    localparam int          BIT_RC        = 1;
    localparam int          BIT_CAPTURE   = 2;
    localparam int          BIT_ER_LO     = 3;
    localparam int          BIT_ER_HI     = 4;
    localparam int          BIT_PUMP      = 6;
    localparam int          BIT_LVI       = 7;
    localparam int          BLOCK_LSB     = 5;
    localparam int          RC_DIV_DEF    = 4;

    typedef enum logic [1:0] {
        MODE_PROGRAM,
        MODE_BYTE_ERASE,
        MODE_BLOCK_ERASE,
        MODE_BULK_ERASE
    } erase_mode_t;

    typedef struct packed {
        logic                  wr;
        logic                  rd;
        logic [ADDR_W-1:0]     addr;
        logic [DATA_W-1:0]     wdata;
    } array_req_t;

    typedef struct packed {
        logic                  pump_on;
        logic                  power_on;
        logic                  rc_clk_sel;
        erase_mode_t           mode;
        logic [ADDR_W-1:0]     addr;
        logic [ADDR_W-1:0]     addr_mask;
        logic [DATA_W-1:0]     data;
    } array_ctrl_t;

endpackage

// ### rtl/rc_clock_sel.sv
// Purpose: Chooses the array clock tick source: CPU clock or internal RC oscillator tick.
// Assumes: RC oscillator modelled as a free divider of clk; with use_rc set, tick is a one-cycle pulse every DIV clocks.
// Notes:   Output is registered so the switch never glitches mid-cycle.
`timescale 1ns/10ps
module rc_clock_sel #(
    parameter int DIV = eeprom_pgm_pkg::RC_DIV_DEF
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic use_rc,
    output logic      tick
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       tick_q;
    logic       tick_d;

    always_comb begin
        cnt_d  = (cnt_q == 8'(DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
        tick_d = use_rc ? (cnt_q == 8'h00) : 1'b1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q  <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
endmodule

// ### rtl/eeprom_pgm_ctrl.sv
// Purpose: Programming control register and array bus capture for on-chip EEPROM.
// Assumes: Register port: reg_addr, reg_wdata, reg_wr, reg_rd; read data one cycle later.
// Notes:   Inhibit flag is an asynchronous analog level and is synchronised first.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module eeprom_pgm_ctrl (
    input  wire logic                                clk,
    input  wire logic                                rst,
    input  wire logic [1:0]                          reg_addr,
    input  wire logic [7:0]                          reg_wdata,
    input  wire logic                                reg_wr,
    input  wire logic                                reg_rd,
    output logic      [7:0]                          reg_rdata,
    input  wire logic                                low_voltage_inhibit_in,
    input  wire eeprom_pgm_pkg::array_req_t          cpu_req,
    output eeprom_pgm_pkg::array_req_t               array_req,
    output logic                                     read_inhibit,
    output eeprom_pgm_pkg::array_ctrl_t              array_ctrl,
    output logic                                     array_tick
);

    ////////////////////////////////////////////////////////////////////////////
    // Inhibit flag synchroniser
    logic lvi_meta_q;
    logic lvi_q;
    logic lvi_meta_d;
    logic lvi_d;

    always_comb begin
        lvi_meta_d = low_voltage_inhibit_in;
        lvi_d      = lvi_meta_q;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lvi_meta_q <= 1'b0;
            lvi_q      <= 1'b0;
        end else begin
            lvi_meta_q <= lvi_meta_d;
            lvi_q      <= lvi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic       wr_ctrl;

    always_comb begin
        wr_ctrl = reg_wr && (reg_addr == eeprom_pgm_pkg::REG_CTRL);
        ctrl_d  = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d[eeprom_pgm_pkg::BIT_RC]      = reg_wdata[eeprom_pgm_pkg::BIT_RC];
            ctrl_d[eeprom_pgm_pkg::BIT_CAPTURE] = reg_wdata[eeprom_pgm_pkg::BIT_CAPTURE];
            ctrl_d[eeprom_pgm_pkg::BIT_ER_LO]   = reg_wdata[eeprom_pgm_pkg::BIT_ER_LO];
            ctrl_d[eeprom_pgm_pkg::BIT_ER_HI]   = reg_wdata[eeprom_pgm_pkg::BIT_ER_HI];
            ctrl_d[eeprom_pgm_pkg::BIT_PUMP]    = reg_wdata[eeprom_pgm_pkg::BIT_PUMP] && !lvi_q;
            // Power write only counts when capture was already set before this write
            if (ctrl_q[eeprom_pgm_pkg::BIT_CAPTURE]) begin
                ctrl_d[eeprom_pgm_pkg::BIT_PGM] = reg_wdata[eeprom_pgm_pkg::BIT_PGM];
            end
        end
        if (lvi_q) begin
            ctrl_d = eeprom_pgm_pkg::CTRL_RESET;
        end
        ctrl_d[eeprom_pgm_pkg::BIT_LVI] = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= eeprom_pgm_pkg::CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array bus capture
    logic                                      capture;
    logic                                      held_q;
    logic                                      held_d;
    logic [eeprom_pgm_pkg::ADDR_W-1:0]         laddr_q;
    logic [eeprom_pgm_pkg::ADDR_W-1:0]         laddr_d;
    logic [eeprom_pgm_pkg::DATA_W-1:0]         ldata_q;
    logic [eeprom_pgm_pkg::DATA_W-1:0]         ldata_d;
    eeprom_pgm_pkg::array_req_t                areq_q;
    eeprom_pgm_pkg::array_req_t                areq_d;

    always_comb begin
        capture = ctrl_q[eeprom_pgm_pkg::BIT_CAPTURE];
        held_d  = capture && (held_q || cpu_req.wr);
        laddr_d = laddr_q;
        ldata_d = ldata_q;
        if (capture && cpu_req.wr) begin
            laddr_d = cpu_req.addr;
            ldata_d = cpu_req.wdata;
        end
        if (!capture) begin
            areq_d = cpu_req;
        end else begin
            // Array only sees the captured address and data; CPU writes are blocked, CPU reads pass until a write is held
            areq_d       = '0;
            areq_d.addr  = laddr_d;
            areq_d.wdata = ldata_d;
            areq_d.rd    = cpu_req.rd && !held_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            held_q  <= 1'b0;
            laddr_q <= '0;
            ldata_q <= '0;
            areq_q  <= '0;
        end else begin
            held_q  <= held_d;
            laddr_q <= laddr_d;
            ldata_q <= ldata_d;
            areq_q  <= areq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Array control outputs
    eeprom_pgm_pkg::array_ctrl_t actl_q;
    eeprom_pgm_pkg::array_ctrl_t actl_d;
    logic                        inh_q;
    logic                        inh_d;

    always_comb begin
        actl_d            = '0;
        actl_d.pump_on    = ctrl_d[eeprom_pgm_pkg::BIT_PUMP];
        actl_d.power_on   = ctrl_d[eeprom_pgm_pkg::BIT_PGM];
        actl_d.rc_clk_sel = ctrl_d[eeprom_pgm_pkg::BIT_RC];
        actl_d.mode       = eeprom_pgm_pkg::erase_mode_t'({ctrl_d[eeprom_pgm_pkg::BIT_ER_HI],
                                                           ctrl_d[eeprom_pgm_pkg::BIT_ER_LO]});
        actl_d.addr       = laddr_d;
        actl_d.data       = ldata_d;
        case (actl_d.mode)
            eeprom_pgm_pkg::MODE_BLOCK_ERASE: begin
                actl_d.addr_mask = eeprom_pgm_pkg::ADDR_W'((1 << eeprom_pgm_pkg::BLOCK_LSB) - 1);
            end
            eeprom_pgm_pkg::MODE_BULK_ERASE: begin
                actl_d.addr_mask = '1;
            end
            default: begin
                actl_d.addr_mask = '0;
            end
        endcase
        inh_d = held_d;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            actl_q <= '0;
            inh_q  <= 1'b0;
        end else begin
            actl_q <= actl_d;
            inh_q  <= inh_d;
        end
    end

    rc_clock_sel u_rc_sel (
        .clk    (clk),
        .rst    (rst),
        .use_rc (ctrl_q[eeprom_pgm_pkg::BIT_RC]),
        .tick   (array_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register read port
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    always_comb begin
        rdata_d = eeprom_pgm_pkg::RD_ZERO;
        if (reg_rd) begin
            case (reg_addr)
                eeprom_pgm_pkg::REG_CTRL: begin
                    rdata_d                          = ctrl_q;
                    rdata_d[eeprom_pgm_pkg::BIT_LVI] = lvi_q;
                end
                eeprom_pgm_pkg::REG_LATCHED: begin
                    rdata_d = 8'(laddr_q);
                end
                eeprom_pgm_pkg::REG_LDATA: begin
                    rdata_d = ldata_q;
                end
                default: begin
                    rdata_d = eeprom_pgm_pkg::RD_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= eeprom_pgm_pkg::RD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata    = rdata_q;
    assign array_req    = areq_q;
    assign read_inhibit = inh_q;
    assign array_ctrl   = actl_q;

endmodule

// ### tb/eeprom_pgm_ctrl_monitor.sv
// Purpose: Port-level checks for the EEPROM program/erase control block.
// Assumes: Inhibit input crosses a two-flop synchroniser before it acts.
// Notes:   Attached by the bind at the foot of this file.
`timescale 1ns/10ps
module eeprom_pgm_ctrl_monitor (
    input wire logic                        clk,
    input wire logic                        rst,
    input wire logic [1:0]                  reg_addr,
    input wire logic [7:0]                  reg_wdata,
    input wire logic                        reg_wr,
    input wire logic                        reg_rd,
    input wire logic [7:0]                  reg_rdata,
    input wire logic                        low_voltage_inhibit_in,
    input wire eeprom_pgm_pkg::array_req_t  cpu_req,
    input wire eeprom_pgm_pkg::array_req_t  array_req,
    input wire logic                        read_inhibit,
    input wire eeprom_pgm_pkg::array_ctrl_t array_ctrl,
    input wire logic                        array_tick
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Three samples cover the synchroniser latency plus the register update
    sequence lvi_held;
        low_voltage_inhibit_in [*3];
    endsequence
    AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    AST_PASS: assert property (array_req.wr |-> $past(cpu_req.wr) &&
        array_req.addr == $past(cpu_req.addr) && array_req.wdata == $past(cpu_req.wdata))
        else $error("array write not a copy of cpu write");
    AST_LVI_POWER: assert property (lvi_held |=> !array_ctrl.power_on)
        else $error("power on under inhibit");
    AST_LVI_RC: assert property (lvi_held |=> !array_ctrl.rc_clk_sel)
        else $error("rc select on under inhibit");
    AST_LVI_BITS: assert property (lvi_held |=> !array_ctrl.pump_on &&
        array_ctrl.mode == eeprom_pgm_pkg::MODE_PROGRAM) else $error("control bits kept under inhibit");
    // Pump output trails the pin by two synchroniser flops plus the output register
    AST_PUMP_BLOCK: assert property ($rose(array_ctrl.pump_on) |-> !$past(low_voltage_inhibit_in, 3))
        else $error("pump set under inhibit");
    AST_POWER_BY_WRITE: assert property ($rose(array_ctrl.power_on) |->
        $past(reg_wr && reg_addr == eeprom_pgm_pkg::REG_CTRL && reg_wdata[0])) else $error("power rose without write");
    AST_MASK: assert property (array_ctrl.addr_mask ==
        (array_ctrl.mode == eeprom_pgm_pkg::MODE_BLOCK_ERASE ? 7'h1F :
         array_ctrl.mode == eeprom_pgm_pkg::MODE_BULK_ERASE ? 7'h7F : 7'h00)) else $error("erase mask wrong");
    AST_INHIBIT_RD: assert property ($past(read_inhibit) && read_inhibit |-> !array_req.rd)
        else $error("array read passed while inhibited");
    AST_TICK_CPU: assert property ((!array_ctrl.rc_clk_sel) [*4] |-> array_tick)
        else $error("tick not steady on cpu clock");
    COV_POWER: cover property ($rose(array_ctrl.power_on));
    COV_LATCH: cover property ($rose(read_inhibit));
    COV_LVI: cover property (lvi_held);
endmodule
bind eeprom_pgm_ctrl eeprom_pgm_ctrl_monitor i_mon (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .low_voltage_inhibit_in, .cpu_req, .array_req, .read_inhibit, .array_ctrl, .array_tick);

// ### tb/testbench.sv
// Purpose: Self-checking bench for the EEPROM program/erase control block.
// Assumes: Register reads answer in the cycle after the strobe.
// Notes:   Reads are scored through a queue; array outputs inline.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", nm, e, g); end end
module testbench;
    logic                        clk = 1'b0;
    logic                        rst = 1'b1;
    logic [1:0]                  reg_addr = 2'h0;
    logic [7:0]                  reg_wdata = 8'h00;
    logic                        reg_wr = 1'b0;
    logic                        reg_rd = 1'b0;
    logic                        low_voltage_inhibit_in = 1'b0;
    eeprom_pgm_pkg::array_req_t  cpu_req = '0;
    eeprom_pgm_pkg::array_req_t  array_req;
    eeprom_pgm_pkg::array_ctrl_t array_ctrl;
    logic [7:0]                  reg_rdata;
    logic                        read_inhibit;
    logic                        array_tick;
    logic [7:0]                  exp_q[$];
    logic [7:0]                  got_e;
    logic                        rd_seen = 1'b0;
    logic [31:0]                 seed = 32'h49;
    logic [6:0]                  a;
    logic [7:0]                  d;
    int                          k;
    int                          miscompares = 0;
    int                          n_checks = 0;
    initial forever #25 clk = ~clk;
    eeprom_pgm_ctrl i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .low_voltage_inhibit_in, .cpu_req, .array_req, .read_inhibit, .array_ctrl, .array_tick);
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction
    task automatic wr(input logic [1:0] ad, input logic [7:0] dt);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= dt;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [1:0] ad, input logic [7:0] ex);
        @(posedge clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        exp_q.push_back(ex);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic cpu(input logic w, input logic [6:0] ad, input logic [7:0] dt);
        @(posedge clk);
        cpu_req <= '{wr: w, rd: !w, addr: ad, wdata: dt};
        @(posedge clk);
        cpu_req <= '0;
        #1;
    endtask
    task automatic final_report();
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read data stands one cycle only, so it is taken on the very next edge
    always @(posedge clk) begin
        if (rd_seen) begin
            got_e = exp_q.pop_front();
            `CHK("reg_rdata", got_e, reg_rdata)
        end
        rd_seen <= reg_rd;
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(2'h0, 8'h00);
        rd(2'h3, 8'h00);
        wr(2'h0, 8'h45);
        rd(2'h0, 8'h44);
        wr(2'h0, 8'h45);
        `CHK("power_on", 1'b1, array_ctrl.power_on)
        `CHK("pump_on", 1'b1, array_ctrl.pump_on)
        for (int m = 0; m < 4; m++) begin
            wr(2'h0, 8'h45 | 8'(m << 3));
            `CHK("mode", m[1:0], array_ctrl.mode)
            rd(2'h0, 8'h45 | 8'(m << 3));
        end
        wr(2'h0, 8'h54);
        a = 7'(rnd());
        d = rnd();
        cpu(1'b1, a, d);
        `CHK("array_wr", 1'b0, array_req.wr)
        `CHK("latched_addr", a, array_ctrl.addr)
        `CHK("latched_data", d, array_ctrl.data)
        `CHK("read_inhibit", 1'b1, read_inhibit)
        rd(2'h1, {1'b0, a});
        rd(2'h2, d);
        cpu(1'b0, a, d);
        `CHK("array_rd", 1'b0, array_req.rd)
        wr(2'h0, 8'h55);
        `CHK("mask", 7'h1F, array_ctrl.addr_mask)
        wr(2'h0, 8'h54);
        `CHK("power_off", 1'b0, array_ctrl.power_on)
        wr(2'h0, 8'h00);
        a = 7'(rnd());
        cpu(1'b1, a, rnd());
        `CHK("pass_wr", 1'b1, array_req.wr)
        `CHK("pass_addr", a, array_req.addr)
        wr(2'h0, 8'h46);
        wr(2'h0, 8'h47);
        // Settle wait before the array relies on the slower tick
        repeat (10) @(posedge clk);
        `CHK("rc_sel", 1'b1, array_ctrl.rc_clk_sel)
        k = 0;
        repeat (8) begin
            @(posedge clk);
            k = k + int'(array_tick);
        end
        `CHK("rc_ticks", 8 / eeprom_pgm_pkg::RC_DIV_DEF, k)
        low_voltage_inhibit_in <= 1'b1;
        repeat (4) @(posedge clk);
        rd(2'h0, 8'h80);
        wr(2'h0, 8'h40);
        rd(2'h0, 8'h80);
        low_voltage_inhibit_in <= 1'b0;
        repeat (4) @(posedge clk);
        rd(2'h0, 8'h00);
        repeat (3) @(posedge clk);
        final_report();
    end
    initial begin
        repeat (3000) @(posedge clk);
        miscompares++;
        final_report();
    end
endmodule
